// [pkg/dfb_pkg.sv]
package dfb_pkg;
    // Clock and millisecond timebase
    localparam int CLK_HZ = 125_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYC = CLK_HZ / MS_PER_S;
    localparam int MS_W = 17;

    // Sizes
    localparam int NIN = 8;
    localparam int NSF = 4;
    localparam int NCRIT = 8;
    localparam int IDX_W = 3;
    localparam int SET_W = 10;

    // Setting limits: 500 ms, 1000 ms, 5 mm/s
    localparam logic [9:0] DEB_MAX = 10'h1F4;
    localparam logic [9:0] DLY_MAX = 10'h3E8;
    localparam logic [9:0] VEL_MAX = 10'h005;

    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FCFG = 8'h04;
    localparam logic [7:0] A_BDLY = 8'h08;
    localparam logic [7:0] A_BMAX = 8'h0C;
    localparam logic [7:0] A_ZLO = 8'h10;
    localparam logic [7:0] A_ZHI = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;

    // Field positions
    localparam int CTRL_BRK_EN = 0;
    localparam int CTRL_BRK_HI = 1;
    localparam int CTRL_PNEU = 2;
    localparam int CTRL_DEMO = 3;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 16;
    localparam int FCFG_W = 8;
    localparam int FCFG_IDX = 0;
    localparam int FCFG_ACT = 4;
    localparam int FCFG_EN = 7;

    // Reset values
    localparam logic [31:0] FCFG_RST = 32'h0000_0000;
    localparam logic [9:0] SET_RST = 10'h000;
    localparam logic [31:0] ZONE_RST = 32'h0000_0000;

    // Input that enables the drive
    localparam int IN_ENABLE = 0;

    // Safety fault responses
    typedef enum logic [1:0] {
        ACT_STOP = 2'h0,
        ACT_DIS = 2'h1,
        ACT_STOP_NF = 2'h2,
        ACT_RSV = 2'h3
    } dfb_act_t;

    // Brake sequencer states
    typedef enum logic [5:0] {
        BRK_OFF = 6'h01,
        BRK_HELD = 6'h02,
        BRK_REL = 6'h04,
        BRK_FREE = 6'h08,
        BRK_SLOW = 6'h10,
        BRK_ENG = 6'h20
    } dfb_brk_t;

    // Status from motion, homing and indexer logic
    typedef struct packed {
        logic moving;
        logic homing;
        logic homed;
        logic idx_run;
        logic move_cmd;
        logic hold_req;
        logic [31:0] pos;
        logic [31:0] cmd_pos;
        logic [15:0] vel;
    } dfb_motion_t;
endpackage : dfb_pkg

// [design/dfb_debounce.sv]
`timescale 1ns/10ps
module dfb_debounce (
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic pin_i, // Raw input pin
    input wire logic tick_i, // One pulse per millisecond
    input wire logic [9:0] lim_i, // Debounce time in ms
    output logic lvl_o // Debounced level
);
    logic sync_a;
    logic sync_b;
    logic [9:0] cnt;
    wire differs = sync_b != lvl_o;
    // One tick past the limit, so a pulse shorter than it never passes
    wire settled = lim_i == 10'h000 || cnt > lim_i;

    // Two-stage synchroniser, first stage read by second only
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
        end
    end

    // New level must hold for the full time; zero passes at once
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 10'h000;
            lvl_o <= 1'b0;
        end else if (!differs) begin
            cnt <= 10'h000;
        end else if (settled) begin
            cnt <= 10'h000;
            lvl_o <= sync_b;
        end else if (tick_i) begin
            cnt <= cnt + 10'h001;
        end
    end
endmodule : dfb_debounce

// [design/dfb_io_fault.sv]
// Notes on behaviour
// - Move-complete low while moving, high after
// - Homed output only when homed, not homing
// - Fault output set when a fault occurs
// - Zone output while position inside bounds
// - In-position when actual equals commanded position
// - Logic-level brake output drives external relay
// - Indexer-complete output only in demo mode
// - Input debounce time settable 0 to 500 ms
// - Power-up move option, else await input change
// - Brake subsystem inactive unless enabled
// - Brake polarity: active low or active high
// - Brake delays accepted from 0 to 1000 ms
// - Maximum brake velocity accepted 0 to 5
// - Critical faults always disable the motor
// - Enabled safety fault raised by high input
// - Disabled safety fault input is ignored
// - Stop-motion fault decelerates and sets fault output
// - Next motion command clears stop-motion fault
// - Disable-motor fault cuts drive power immediately
// - Disabled until enable low-high cycle or power
// - Stop without fault output leaves it low
// - Both stop responses use maximum deceleration
// - Latest fault decides motor and fault output; the code keeps a motor disable until the enable cycle, whatever fault follows
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
module dfb_io_fault #(
    parameter int MS_CYC = dfb_pkg::MS_CYC // Cycles per millisecond
) (
    input wire logic mclk_i, // System clock, 125 MHz
    input wire logic rst_n_i, // Async reset, active low
    input wire logic [dfb_pkg::NIN-1:0] din_i, // Digital input pins
    input wire logic [dfb_pkg::NCRIT-1:0] crit_i, // Critical fault levels
    input wire dfb_pkg::dfb_motion_t motion_i, // Motion status
    input wire logic [7:0] addr_i, // Register byte address
    input wire logic [31:0] wdata_i, // Register write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [31:0] rdata_o, // Read data, cycle after strobe
    output logic move_done_o, // Motion finished
    output logic homed_o, // Axis homed
    output logic fault_o, // Fault output
    output logic zone_o, // Inside zone bounds
    output logic inpos_o, // At commanded position
    output logic brake_o, // Brake relay drive
    output logic idx_done_o, // Indexer sequence finished
    output logic motor_en_o, // Drive power to motor
    output logic stop_maxdec_o, // Stop at maximum deceleration
    output logic pwrup_go_o, // Pulse: power-up move
    output logic motion_arm_o, // Motion may start
    output logic [dfb_pkg::NIN-1:0] din_deb_o // Debounced inputs
);
    localparam int MSW = dfb_pkg::MS_W;
    localparam int NSF = dfb_pkg::NSF;
    localparam int FW = dfb_pkg::FCFG_W;

    // Configuration and state
    logic brk_en, brk_hi, pneu, demo;
    logic [9:0] deb_ms, rel_dly, eng_dly, max_dly, max_vel;
    logic [31:0] fcfg, zlo, zhi;
    logic [MSW-1:0] ms_cnt;
    logic ms_tick;
    logic fault_out, motor_dis, stop_req, armed;
    logic next_fault, next_dis, next_stop;
    logic en_q;
    logic [dfb_pkg::NCRIT-1:0] crit_q;
    logic [NSF-1:0] sf_cond, sf_q;
    logic [dfb_pkg::NIN-1:0] deb_q;
    logic ev_any;
    dfb_pkg::dfb_act_t ev_act;
    dfb_pkg::dfb_act_t sf_act [NSF];
    dfb_pkg::dfb_brk_t brk_st, next_brk;
    logic [9:0] brk_cnt, next_cnt;
    logic [31:0] rd_val;

    // Clamp a setting to its allowed range
    function automatic logic [9:0] sat(input logic [9:0] v,
                                       input logic [9:0] m);
        sat = (v > m) ? m : v;
    endfunction : sat

    // Write decode
    wire wr_ctrl = wr_i && addr_i == dfb_pkg::A_CTRL;
    wire wr_fcfg = wr_i && addr_i == dfb_pkg::A_FCFG;
    wire wr_bdly = wr_i && addr_i == dfb_pkg::A_BDLY;
    wire wr_bmax = wr_i && addr_i == dfb_pkg::A_BMAX;
    wire wr_zlo = wr_i && addr_i == dfb_pkg::A_ZLO;
    wire wr_zhi = wr_i && addr_i == dfb_pkg::A_ZHI;
    wire [9:0] w_lo = wdata_i[dfb_pkg::LO_LSB +: dfb_pkg::SET_W];
    wire [9:0] w_hi = wdata_i[dfb_pkg::HI_LSB +: dfb_pkg::SET_W];

    // Settings registers; out-of-range writes saturate
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {brk_en, brk_hi, pneu, demo} <= 4'h0;
            deb_ms <= dfb_pkg::SET_RST;
            fcfg <= dfb_pkg::FCFG_RST;
            {rel_dly, eng_dly} <= {dfb_pkg::SET_RST, dfb_pkg::SET_RST};
            {max_dly, max_vel} <= {dfb_pkg::SET_RST, dfb_pkg::SET_RST};
            zlo <= dfb_pkg::ZONE_RST;
            zhi <= dfb_pkg::ZONE_RST;
        end else begin
            if (wr_ctrl) begin
                brk_en <= wdata_i[dfb_pkg::CTRL_BRK_EN];
                brk_hi <= wdata_i[dfb_pkg::CTRL_BRK_HI];
                pneu <= wdata_i[dfb_pkg::CTRL_PNEU];
                demo <= wdata_i[dfb_pkg::CTRL_DEMO];
                deb_ms <= sat(w_hi, dfb_pkg::DEB_MAX);
            end
            if (wr_fcfg) fcfg <= wdata_i;
            if (wr_bdly) begin
                rel_dly <= sat(w_lo, dfb_pkg::DLY_MAX);
                eng_dly <= sat(w_hi, dfb_pkg::DLY_MAX);
            end
            if (wr_bmax) begin
                max_dly <= sat(w_lo, dfb_pkg::DLY_MAX);
                max_vel <= sat(w_hi, dfb_pkg::VEL_MAX);
            end
            if (wr_zlo) zlo <= wdata_i;
            if (wr_zhi) zhi <= wdata_i;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        unique case (addr_i)
            dfb_pkg::A_CTRL: rd_val = {6'h00, deb_ms, 12'h000,
                                       demo, pneu, brk_hi, brk_en};
            dfb_pkg::A_FCFG: rd_val = fcfg;
            dfb_pkg::A_BDLY: rd_val = {6'h00, eng_dly, 6'h00, rel_dly};
            dfb_pkg::A_BMAX: rd_val = {6'h00, max_vel, 6'h00, max_dly};
            dfb_pkg::A_ZLO: rd_val = zlo;
            dfb_pkg::A_ZHI: rd_val = zhi;
            dfb_pkg::A_STAT: rd_val = {10'h000, brk_st, din_deb_o,
                                       4'h0, armed, stop_req,
                                       motor_dis, fault_out};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) rdata_o <= 32'h0000_0000;
        else rdata_o <= rd_i ? rd_val : 32'h0000_0000;
    end

    // Millisecond timebase shared by debounce and brake delays
    wire ms_wrap = ms_cnt == MSW'(MS_CYC - 1);
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ms_cnt <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_cnt <= ms_wrap ? '0 : ms_cnt + MSW'(1);
            ms_tick <= ms_wrap;
        end
    end

    // One filter per pin, ahead of every consumer
    genvar gi;
    generate
        for (gi = 0; gi < dfb_pkg::NIN; gi++) begin : g_deb
            dfb_debounce u_deb (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .pin_i(din_i[gi]),
                .tick_i(ms_tick),
                .lim_i(deb_ms),
                .lvl_o(din_deb_o[gi])
            );
        end
    endgenerate

    // Per fault: enable, response and assigned input
    generate
        for (gi = 0; gi < NSF; gi++) begin : g_sf
            wire [dfb_pkg::IDX_W-1:0] sel =
                fcfg[gi*FW+dfb_pkg::FCFG_IDX +: dfb_pkg::IDX_W];
            assign sf_cond[gi] = fcfg[gi*FW+dfb_pkg::FCFG_EN]
                                 & din_deb_o[sel];
            assign sf_act[gi] = dfb_pkg::dfb_act_t'(
                fcfg[gi*FW+dfb_pkg::FCFG_ACT +: 2]);
        end
    endgenerate

    // Onsets of faults and of enable
    wire [NSF-1:0] sf_rise = sf_cond & ~sf_q;
    wire crit_any = |crit_i;
    wire crit_rise = |(crit_i & ~crit_q);
    wire en_deb = din_deb_o[dfb_pkg::IN_ENABLE];
    wire en_rise = en_deb & ~en_q;

    // No priority: the highest index among same-cycle onsets wins
    always_comb begin
        ev_any = 1'b0;
        ev_act = dfb_pkg::ACT_STOP;
        for (int f = 0; f < NSF; f++) begin
            if (sf_rise[f]) begin
                ev_any = 1'b1;
                ev_act = sf_act[f];
            end
        end
    end

    // Fault state: clears first, so a same-cycle onset wins
    always_comb begin
        next_fault = fault_out;
        next_dis = motor_dis;
        next_stop = stop_req;
        if (motion_i.move_cmd && !motor_dis) begin
            next_stop = 1'b0;
            next_fault = 1'b0;
        end
        if (en_rise && !crit_any) begin
            next_dis = 1'b0;
            next_fault = 1'b0;
            next_stop = 1'b0;
        end
        if (ev_any) begin
            unique case (ev_act)
                dfb_pkg::ACT_DIS: begin
                    next_dis = 1'b1;
                    next_fault = 1'b1;
                end
                dfb_pkg::ACT_STOP_NF: begin
                    next_stop = 1'b1;
                    next_fault = 1'b0;
                end
                default: begin
                    next_stop = 1'b1;
                    next_fault = 1'b1;
                end
            endcase
        end
        if (crit_rise) next_fault = 1'b1;
        if (crit_any) next_dis = 1'b1;
    end

    // Fault and power-up state registers
    wire din_moved = din_deb_o != deb_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_out <= 1'b0;
            motor_dis <= 1'b0;
            stop_req <= 1'b0;
            en_q <= 1'b0;
            crit_q <= '0;
            sf_q <= '0;
            deb_q <= '0;
            armed <= 1'b0;
            pwrup_go_o <= 1'b0;
        end else begin
            fault_out <= next_fault;
            motor_dis <= next_dis;
            stop_req <= next_stop;
            en_q <= en_deb;
            crit_q <= crit_i;
            sf_q <= sf_cond;
            deb_q <= din_deb_o;
            pwrup_go_o <= !armed && pneu;
            if (!armed && (pneu || din_moved)) armed <= 1'b1;
        end
    end

    // Brake sequencer; delay counts in milliseconds
    wire slow_ok = motion_i.vel <= {6'h00, max_vel};
    wire run = motor_en_o;
    always_comb begin
        next_brk = brk_st;
        next_cnt = ms_tick ? brk_cnt + 10'h001 : brk_cnt;
        unique case (brk_st)
            dfb_pkg::BRK_OFF: if (brk_en) next_brk = dfb_pkg::BRK_HELD;
            dfb_pkg::BRK_HELD: if (run) next_brk = dfb_pkg::BRK_REL;
            dfb_pkg::BRK_REL:
                if (!run) next_brk = dfb_pkg::BRK_HELD;
                else if (brk_cnt >= rel_dly) next_brk = dfb_pkg::BRK_FREE;
            dfb_pkg::BRK_FREE:
                if (!run) next_brk = dfb_pkg::BRK_HELD;
                else if (motion_i.hold_req) next_brk = dfb_pkg::BRK_SLOW;
            dfb_pkg::BRK_SLOW:
                if (!run) next_brk = dfb_pkg::BRK_HELD;
                else if (slow_ok || brk_cnt >= max_dly)
                    next_brk = dfb_pkg::BRK_ENG;
            dfb_pkg::BRK_ENG:
                if (brk_cnt >= eng_dly) next_brk = dfb_pkg::BRK_HELD;
            default: next_brk = dfb_pkg::BRK_OFF;
        endcase
        if (!brk_en) next_brk = dfb_pkg::BRK_OFF;
        if (next_brk != brk_st) next_cnt = 10'h000;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            brk_st <= dfb_pkg::BRK_OFF;
            brk_cnt <= 10'h000;
        end else begin
            brk_st <= next_brk;
            brk_cnt <= next_cnt;
        end
    end

    // Brake engaged in all active states except released ones
    wire engaged = brk_st != dfb_pkg::BRK_FREE
                   && brk_st != dfb_pkg::BRK_SLOW;
    wire brk_drv = brk_st != dfb_pkg::BRK_OFF
                   && (brk_hi ? engaged : !engaged);
    wire [31:0] pos = motion_i.pos;
    wire in_zone = $signed(pos) >= $signed(zlo)
                   && $signed(pos) <= $signed(zhi);

    // Registered status outputs
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            move_done_o <= 1'b0;
            homed_o <= 1'b0;
            fault_o <= 1'b0;
            zone_o <= 1'b0;
            inpos_o <= 1'b0;
            brake_o <= 1'b0;
            idx_done_o <= 1'b0;
            motor_en_o <= 1'b0;
            stop_maxdec_o <= 1'b0;
            motion_arm_o <= 1'b0;
        end else begin
            move_done_o <= !motion_i.moving;
            homed_o <= motion_i.homed && !motion_i.homing;
            fault_o <= fault_out;
            zone_o <= in_zone;
            inpos_o <= pos == motion_i.cmd_pos;
            brake_o <= brk_drv;
            idx_done_o <= demo && !motion_i.idx_run;
            motor_en_o <= en_deb && !motor_dis;
            stop_maxdec_o <= stop_req;
            motion_arm_o <= armed;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_MOVE_DONE: assert property (
        motion_i.moving |=> !move_done_o)
        else $error("move complete high during motion");
    AST_HOMED: assert property (
        motion_i.homing |=> !homed_o)
        else $error("homed output high while homing");
    AST_ZONE: assert property (
        in_zone |=> zone_o)
        else $error("zone output low inside bounds");
    AST_INPOS: assert property (
        (pos == motion_i.cmd_pos) |=> inpos_o)
        else $error("in position low at commanded position");
    AST_IDX_DEMO: assert property (
        !demo |=> !idx_done_o)
        else $error("indexer output outside demo mode");
    AST_BRK_OFF: assert property (
        !brk_en [*2] |=> !brake_o)
        else $error("brake driven while disabled");
    AST_DEB_RANGE: assert property (
        wr_ctrl |=> deb_ms <= dfb_pkg::DEB_MAX)
        else $error("debounce time above limit");
    AST_CRIT: assert property (
        crit_any |=> motor_dis ##1 !motor_en_o)
        else $error("critical fault left motor enabled");
    AST_DIS: assert property (
        ev_any && ev_act == dfb_pkg::ACT_DIS
        |=> motor_dis && fault_out ##1 !motor_en_o && fault_o)
        else $error("disable fault did not cut power");
    AST_STOP_NF: assert property (
        ev_any && ev_act == dfb_pkg::ACT_STOP_NF && !crit_rise
        |=> stop_req && !fault_out ##1 stop_maxdec_o && !fault_o)
        else $error("stop without fault output raised fault");
    AST_REENABLE: assert property (
        en_rise && !crit_any && !ev_any |=> !motor_dis)
        else $error("enable cycle did not re-enable");
endmodule : dfb_io_fault

// [verification/dfb_plc_model.sv]
`timescale 1ns/10ps
module dfb_plc_model (
    input wire logic mclk_i, // System clock
    output logic [dfb_pkg::NIN-1:0] din_o // Drive input pins
);
    // Relay outputs start open; pins move just after an edge
    initial din_o = 8'h00;
    task set_pin(input int i, input logic v);
        @(posedge mclk_i);
        din_o[i] <= v;
    endtask : set_pin
    // Enable low then high, the only way back from a motor disable
    task cycle_en();
        set_pin(0, 1'b0);
        repeat (6) @(posedge mclk_i); // Longer than sync and filter
        set_pin(0, 1'b1);
    endtask : cycle_en
endmodule : dfb_plc_model

// [verification/test_drive_io_fault_brake_logic.sv]
`timescale 1ns/10ps
`define CHK(g, e) chk((g) === (e))
module test_drive_io_fault_brake_logic;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] din;
    logic [7:0] crit = 8'h00;
    dfb_pkg::dfb_motion_t mo = '0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic move_done, homed, fault, zone, inpos, brake, idx_done;
    logic motor_en, stop_md, pwrup_go, arm;
    logic [7:0] din_deb;
    logic [31:0] d;
    int fail_count = 0;
    int samples_checked = 0;

    // 125 MHz system clock
    always #4 mclk = ~mclk;

    dfb_plc_model plc (.mclk_i(mclk), .din_o(din));
    // Short millisecond keeps every delay within a few dozen cycles
    dfb_io_fault #(.MS_CYC(10)) dut (
        .mclk_i(mclk), .rst_n_i(rst_n), .din_i(din), .crit_i(crit),
        .motion_i(mo), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .move_done_o(move_done),
        .homed_o(homed), .fault_o(fault), .zone_o(zone),
        .inpos_o(inpos), .brake_o(brake), .idx_done_o(idx_done),
        .motor_en_o(motor_en), .stop_maxdec_o(stop_md),
        .pwrup_go_o(pwrup_go), .motion_arm_o(arm), .din_deb_o(din_deb)
    );

    task chk(input logic ok);
        samples_checked++;
        if (!ok) begin
            fail_count++;
            $display("MISMATCH t=%0t value differs", $time);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task do_reset();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
    endtask : do_reset
    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data are valid only in the cycle after the strobe
    task rd_reg(input logic [7:0] a);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task pin(input int i, input logic v, input int w);
        plc.set_pin(i, v);
        cyc(w);
    endtask : pin
    task mv_cmd();
        @(posedge mclk);
        mo.move_cmd <= 1'b1;
        @(posedge mclk);
        mo.move_cmd <= 1'b0;
        cyc(3);
    endtask : mv_cmd
    task setm(input dfb_pkg::dfb_motion_t m);
        @(posedge mclk);
        mo <= m;
        cyc(2);
    endtask : setm

    task t_pwrup();
        int n;
        cyc(2);
        `CHK(arm, 1'b0);
        wr_reg(8'h00, 32'h0000_0004);
        for (n = 0; n < 10 && pwrup_go !== 1'b1; n++) cyc(1);
        `CHK(pwrup_go, 1'b1);
        cyc(1);
        `CHK(pwrup_go, 1'b0);
        `CHK(arm, 1'b1);
        // Without the option only an input change arms motion
        do_reset();
        cyc(4);
        `CHK(arm, 1'b0);
        pin(0, 1'b1, 8);
        `CHK(arm, 1'b1);
        `CHK(motor_en, 1'b1);
        $display("test pwrup done");
    endtask : t_pwrup

    task t_regs();
        rd_reg(8'h1C);
        `CHK(d, 32'h0000_0000);
        wr_reg(8'h00, 32'h03FF_0000);
        rd_reg(8'h00);
        `CHK(d, 32'h01F4_0000);
        wr_reg(8'h08, 32'h07FF_07FF);
        rd_reg(8'h08);
        `CHK(d, 32'h03E8_03E8);
        wr_reg(8'h0C, 32'h07FF_07FF);
        rd_reg(8'h0C);
        `CHK(d, 32'h0005_03E8);
        wr_reg(8'h10, 32'hFFFF_FFF6);
        wr_reg(8'h14, 32'h0000_0014);
        rd_reg(8'h10);
        `CHK(d, 32'hFFFF_FFF6);
        // A glitch shorter than 1 ms must not pass the filter
        wr_reg(8'h00, 32'h0001_0000);
        pin(6, 1'b1, 2);
        pin(6, 1'b0, 30);
        `CHK(din_deb[6], 1'b0);
        pin(6, 1'b1, 40);
        `CHK(din_deb[6], 1'b1);
        pin(6, 1'b0, 1);
        wr_reg(8'h00, 32'h0000_0000);
        cyc(40);
        $display("test regs done");
    endtask : t_regs

    task t_status();
        dfb_pkg::dfb_motion_t m;
        m = mo;
        m.moving = 1'b1;
        m.homing = 1'b1;
        m.homed = 1'b1;
        m.idx_run = 1'b1;
        m.pos = 32'h0000_000F;
        m.cmd_pos = 32'h0000_0010;
        setm(m);
        `CHK(move_done, 1'b0);
        `CHK(homed, 1'b0);
        `CHK(zone, 1'b1);
        `CHK(inpos, 1'b0);
        m.moving = 1'b0;
        m.homing = 1'b0;
        m.idx_run = 1'b0;
        m.pos = 32'h0000_0010;
        setm(m);
        `CHK(move_done, 1'b1);
        `CHK(homed, 1'b1);
        `CHK(inpos, 1'b1);
        `CHK(idx_done, 1'b0);
        wr_reg(8'h00, 32'h0000_0008);
        m.pos = 32'h0000_0015;
        m.homed = 1'b0;
        setm(m);
        `CHK(zone, 1'b0);
        `CHK(idx_done, 1'b1);
        `CHK(homed, 1'b0);
        wr_reg(8'h00, 32'h0000_0000);
        $display("test status done");
    endtask : t_status

    task t_fault();
        // Faults 0..3 on inputs 1,2,3,5: stop, disable, quiet, off
        wr_reg(8'h04, 32'h35A3_9281);
        pin(1, 1'b1, 8);
        `CHK(fault, 1'b1);
        `CHK(stop_md, 1'b1);
        `CHK(motor_en, 1'b1);
        pin(1, 1'b0, 1);
        mv_cmd();
        `CHK(fault, 1'b0);
        `CHK(stop_md, 1'b0);
        pin(5, 1'b1, 8);
        `CHK(fault, 1'b0);
        pin(5, 1'b0, 1);
        pin(2, 1'b1, 8);
        `CHK(motor_en, 1'b0);
        `CHK(fault, 1'b1);
        pin(2, 1'b0, 1);
        mv_cmd();
        `CHK(motor_en, 1'b0);
        pin(3, 1'b1, 8);
        `CHK(fault, 1'b0);
        `CHK(motor_en, 1'b0);
        pin(3, 1'b0, 1);
        plc.cycle_en();
        cyc(8);
        `CHK(motor_en, 1'b1);
        // Action code 3 behaves as a stop
        wr_reg(8'h04, 32'hB5A3_9281);
        pin(5, 1'b1, 8);
        `CHK(stop_md, 1'b1);
        pin(5, 1'b0, 1);
        mv_cmd();
        @(posedge mclk);
        crit <= 8'h04;
        cyc(4);
        `CHK(motor_en, 1'b0);
        `CHK(fault, 1'b1);
        plc.cycle_en();
        cyc(8);
        `CHK(motor_en, 1'b0);
        @(posedge mclk);
        crit <= 8'h00;
        plc.cycle_en();
        cyc(8);
        `CHK(motor_en, 1'b1);
        `CHK(fault, 1'b0);
        $display("test fault done");
    endtask : t_fault

    task t_brake();
        dfb_pkg::dfb_motion_t m;
        wr_reg(8'h08, 32'h0002_0002);
        wr_reg(8'h0C, 32'h0001_0003);
        `CHK(brake, 1'b0);
        // Critical level keeps the motor off, so the brake holds
        @(posedge mclk);
        crit <= 8'h04;
        cyc(4);
        wr_reg(8'h00, 32'h0000_0003);
        cyc(3);
        `CHK(brake, 1'b1);
        wr_reg(8'h00, 32'h0000_0001);
        cyc(3);
        `CHK(brake, 1'b0);
        wr_reg(8'h00, 32'h0000_0003);
        @(posedge mclk);
        crit <= 8'h00;
        plc.cycle_en();
        cyc(8);
        rd_reg(8'h18);
        `CHK(d[21:16], 6'h04);
        cyc(40);
        rd_reg(8'h18);
        `CHK(d[21:16], 6'h08);
        `CHK(brake, 1'b0);
        m = mo;
        m.hold_req = 1'b1;
        m.vel = 16'h0003;
        setm(m);
        cyc(8);
        rd_reg(8'h18);
        `CHK(d[21:16], 6'h10);
        cyc(24); // Mid engage window whatever the tick phase
        rd_reg(8'h18);
        `CHK(d[21:16], 6'h20);
        m.hold_req = 1'b0;
        m.vel = 16'h0000;
        setm(m);
        wr_reg(8'h00, 32'h0000_0000);
        cyc(2);
        `CHK(brake, 1'b0);
        rd_reg(8'h18);
        `CHK(d[21:16], 6'h01);
        $display("test brake done");
    endtask : t_brake

    task summarize();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Tests need about 450 cycles; allow ample margin
    initial begin
        #50us;
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end

    initial begin
        do_reset();
        t_pwrup();
        t_regs();
        t_status();
        t_fault();
        t_brake();
        summarize();
    end
endmodule : test_drive_io_fault_brake_logic
